// ---- hdl/tmau_pkg.sv ----
// Purpose: constants and types for the translation miss assist unit
// Assumes: big-endian bit n of a 32-bit word sits at index 31-n
// Notes:   rule summary below
//
// Functional notes
// - Instruction fetch miss in instruction buffer vectors to offset 0x1000.
// - Load miss in data buffer vectors to offset 0x1100.
// - Store miss, or store hit with changed bit clear, vectors to 0x1200.
// - Miss loads the instruction or data miss address with the full address.
// - Miss builds the compare word software matches against entry word one.
// - Miss computes primary and secondary group addresses from the miss address.
// - Entry loads write compare and physical words into entry picked by address, way.
// - Any miss sets the temporary register select bit.
// - Return restores machine state from saved status, clearing temporary select.
// - Miss copies condition field zero into saved bits 0-3; software restores it.
// - Saved bit 13 marks instruction miss; bit 15 marks data load miss.
// - Saved bit 14 holds replacement way; software may override; loads use it.
// - Saved bit 12 holds supervisor key if problem state clear, else user key.
// - Support registers are supervisor only; user access raises privilege fault.
// - Any exception entry clears both translation enable bits.
// - Compare word: bit 0 set, bit 25 clear, id bits 1-24, page index 26-31.
// - Group address bits 0-6 from table base origin, low six bits zero.
package tmau_pkg;

	localparam logic [31:0] TMAU_VEC_INSTR_MISS_ADDRESS  = 32'h0000_1000;
	localparam logic [31:0] TMAU_VEC_DLOAD  = 32'h0000_1100;
	localparam logic [31:0] TMAU_VEC_DSTORE = 32'h0000_1200;

	// Little-endian indices of big-endian bit numbers
	localparam int TMAU_SS_KEY   = 31 - 12;
	localparam int TMAU_SS_INSTR = 31 - 13;
	localparam int TMAU_SS_WAY   = 31 - 14;
	localparam int TMAU_SS_LOAD  = 31 - 15;
	localparam int TMAU_MS_TEMP_REGISTER_SELECT  = 31 - 14;
	localparam int TMAU_MS_PR    = 31 - 17;
	localparam int TMAU_MS_IR    = 31 - 26;
	localparam int TMAU_MS_DR    = 31 - 27;

	localparam logic [31:0] TMAU_MS_RESET = 32'h0000_0000;
	localparam logic [31:0] TMAU_SS_RESET = 32'h0000_0000;
	localparam logic [31:0] TMAU_W_RESET  = 32'h0000_0000;
	localparam logic [15:0] TMAU_SS_LOW_MASK = 16'hFFFF;

	// Special register selects
	typedef enum logic [3:0] {
		TMAU_SEL_INSTR_MISS_ADDRESS = 4'h0,
		TMAU_SEL_DATA_MISS_ADDRESS = 4'h1,
		TMAU_SEL_INSTR_COMPARE_WORD  = 4'h2,
		TMAU_SEL_DATA_COMPARE_WORD  = 4'h3,
		TMAU_SEL_PRIM  = 4'h4,
		TMAU_SEL_SEC   = 4'h5,
		TMAU_SEL_PHYS  = 4'h6,
		TMAU_SEL_SAVED = 4'h7,
		TMAU_SEL_MSTAT = 4'h8,
		TMAU_SEL_TBASE = 4'h9
	} tmau_sel_t;

	typedef struct packed {
		logic        req;
		logic        we;
		tmau_sel_t   sel;
		logic [31:0] wdata;
	} tmau_spr_req_t;

	typedef struct packed {
		logic        instr;
		logic        data;
		logic [4:0]  index;
		logic        way;
		logic [31:0] cmp;
		logic [31:0] phys;
	} tmau_tlbw_t;

endpackage

// ---- hdl/tmau_top.sv ----
// Purpose: translation miss assist: vectors, captured words, saved status, entry loads
// Assumes: all inputs synchronous to REF_CLK; one event per cycle from the core
// Notes:   hashing is a plain fold; page fault handling lives in software
`timescale 1ns/1ps
`default_nettype none
module tmau_top
	import tmau_pkg::*;
(
	input  wire logic          REF_CLK,
	input  wire logic          RST_N,
	input  wire logic          IFETCH_MISS,
	input  wire logic          DATA_MISS,
	input  wire logic          DATA_STORE_C0,
	input  wire logic          DATA_IS_LOAD,
	input  wire logic          OTHER_EXC,
	input  wire logic          RFI,
	input  wire logic [31:0]   MISS_EA,
	input  wire logic [23:0]   SEGMENT_VIRTUAL_ID,
	input  wire logic          SUPERVISOR_KEY,
	input  wire logic          USER_KEY,
	input  wire logic [3:0]    CONDITION_FIELD_ZERO,
	input  wire logic          INSTR_LRU_WAY,
	input  wire logic          DATA_LRU_WAY,
	input  wire tmau_spr_req_t SPR_REQ,
	input  wire logic          ILOAD_REQ,
	input  wire logic          DLOAD_REQ,
	input  wire logic [31:0]   LOAD_EA,
	output logic               EXC_TAKEN,
	output logic [31:0]        EXC_VECTOR,
	output logic [31:0]        SPR_RDATA,
	output logic               PRIV_FAULT,
	output logic [31:0]        MACHINE_STATE,
	output logic               TEMP_REGISTER_SELECT,
	output tmau_tlbw_t         TLB_WRITE
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] group_addr(input logic [31:0] tbase,
		input logic [18:0] hashed);
		group_addr = {tbase[31:25], hashed, 6'h00};
	endfunction

	function automatic logic [18:0] primary_hash(input logic [23:0] segment_virtual_id,
		input logic [31:0] ea);
		primary_hash = segment_virtual_id[18:0] ^ {3'h0, ea[27:12]};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] instr_miss_address_r, instr_miss_address_nxt, data_miss_address_r, data_miss_address_nxt;
	logic [31:0] instr_compare_word_r, instr_compare_word_nxt, data_compare_word_r, data_compare_word_nxt;
	logic [31:0] prim_r, prim_nxt, sec_r, sec_nxt;
	logic [31:0] phys_r, phys_nxt, saved_r, saved_nxt;
	logic [31:0] mstat_r, mstat_nxt, tbase_r, tbase_nxt;
	logic        exc_r, exc_nxt;
	logic [31:0] vec_r, vec_nxt, rdata_r, rdata_nxt;
	logic        fault_r, fault_nxt;
	tmau_tlbw_t  tlbw_r, tlbw_nxt;

	logic        any_miss;
	logic        data_miss_address_ev;
	logic [31:0] cmp_word;
	logic [18:0] hash_p;
	logic        user_mode;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		user_mode = mstat_r[TMAU_MS_PR];
		data_miss_address_ev  = DATA_MISS | DATA_STORE_C0;
		any_miss  = IFETCH_MISS | data_miss_address_ev;
		cmp_word  = {1'b1, SEGMENT_VIRTUAL_ID, 1'b0, MISS_EA[27:22]};
		hash_p    = primary_hash(SEGMENT_VIRTUAL_ID, MISS_EA);

		instr_miss_address_nxt = instr_miss_address_r;
		data_miss_address_nxt = data_miss_address_r;
		instr_compare_word_nxt  = instr_compare_word_r;
		data_compare_word_nxt  = data_compare_word_r;
		prim_nxt  = prim_r;
		sec_nxt   = sec_r;
		phys_nxt  = phys_r;
		saved_nxt = saved_r;
		mstat_nxt = mstat_r;
		tbase_nxt = tbase_r;
		exc_nxt   = 1'b0;
		vec_nxt   = vec_r;
		rdata_nxt = rdata_r;
		fault_nxt = 1'b0;
		tlbw_nxt  = tlbw_r;
		tlbw_nxt.instr = 1'b0;
		tlbw_nxt.data  = 1'b0;

		// Special register access; user level is refused outright
		if (SPR_REQ.req) begin
			if (user_mode) begin
				fault_nxt = 1'b1;
			end else begin
				case (SPR_REQ.sel)
					TMAU_SEL_INSTR_MISS_ADDRESS: rdata_nxt = instr_miss_address_r;
					TMAU_SEL_DATA_MISS_ADDRESS: rdata_nxt = data_miss_address_r;
					TMAU_SEL_INSTR_COMPARE_WORD:  rdata_nxt = instr_compare_word_r;
					TMAU_SEL_DATA_COMPARE_WORD:  rdata_nxt = data_compare_word_r;
					TMAU_SEL_PRIM:  rdata_nxt = prim_r;
					TMAU_SEL_SEC:   rdata_nxt = sec_r;
					TMAU_SEL_PHYS:  rdata_nxt = phys_r;
					TMAU_SEL_SAVED: rdata_nxt = saved_r;
					TMAU_SEL_MSTAT: rdata_nxt = mstat_r;
					TMAU_SEL_TBASE: rdata_nxt = tbase_r;
					default:        rdata_nxt = TMAU_W_RESET;
				endcase
				// Miss, compare and group words are read-only
				if (SPR_REQ.we) begin
					case (SPR_REQ.sel)
						TMAU_SEL_PHYS:  phys_nxt  = SPR_REQ.wdata;
						TMAU_SEL_SAVED: saved_nxt = SPR_REQ.wdata;
						TMAU_SEL_MSTAT: mstat_nxt = SPR_REQ.wdata;
						TMAU_SEL_TBASE: tbase_nxt = SPR_REQ.wdata;
						default:        phys_nxt  = phys_r;
					endcase
				end
			end
		end

		// Entry loads use the saved way bit, including any software override
		if (ILOAD_REQ | DLOAD_REQ) begin
			if (user_mode) begin
				fault_nxt = 1'b1;
			end else begin
				tlbw_nxt.instr = ILOAD_REQ;
				tlbw_nxt.data  = DLOAD_REQ & ~ILOAD_REQ;
				tlbw_nxt.index = LOAD_EA[16:12];
				tlbw_nxt.way   = saved_r[TMAU_SS_WAY];
				tlbw_nxt.cmp   = ILOAD_REQ ? instr_compare_word_r : data_compare_word_r;
				tlbw_nxt.phys  = phys_r;
			end
		end

		// Return restores state; upper saved bits never reach machine state
		if (RFI) begin
			mstat_nxt = {16'h0000, saved_r[15:0] & TMAU_SS_LOW_MASK};
		end

		// Exception entry; instruction miss wins over a same-cycle data miss
		if (any_miss) begin
			exc_nxt = 1'b1;
			saved_nxt = {CONDITION_FIELD_ZERO, 8'h00, 4'h0, mstat_r[15:0]};
			saved_nxt[TMAU_SS_KEY] = user_mode ? USER_KEY : SUPERVISOR_KEY;
			prim_nxt = group_addr(tbase_r, hash_p);
			sec_nxt  = group_addr(tbase_r, ~hash_p);
			if (IFETCH_MISS) begin
				vec_nxt  = TMAU_VEC_INSTR_MISS_ADDRESS;
				instr_miss_address_nxt = MISS_EA;
				instr_compare_word_nxt  = cmp_word;
				saved_nxt[TMAU_SS_INSTR] = 1'b1;
				saved_nxt[TMAU_SS_WAY]   = INSTR_LRU_WAY;
			end else begin
				data_miss_address_nxt = MISS_EA;
				data_compare_word_nxt  = cmp_word;
				saved_nxt[TMAU_SS_WAY] = DATA_LRU_WAY;
				if (DATA_MISS & DATA_IS_LOAD) begin
					vec_nxt = TMAU_VEC_DLOAD;
					saved_nxt[TMAU_SS_LOAD] = 1'b1;
				end else begin
					vec_nxt = TMAU_VEC_DSTORE;
				end
			end
			mstat_nxt = mstat_r;
			mstat_nxt[TMAU_MS_TEMP_REGISTER_SELECT] = 1'b1;
			mstat_nxt[TMAU_MS_IR]   = 1'b0;
			mstat_nxt[TMAU_MS_DR]   = 1'b0;
		end else if (OTHER_EXC) begin
			// Builds on any same-cycle return so the scratch select stays cleared
			mstat_nxt[TMAU_MS_IR] = 1'b0;
			mstat_nxt[TMAU_MS_DR] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			instr_miss_address_r <= TMAU_W_RESET;
			data_miss_address_r <= TMAU_W_RESET;
			instr_compare_word_r  <= TMAU_W_RESET;
			data_compare_word_r  <= TMAU_W_RESET;
			prim_r  <= TMAU_W_RESET;
			sec_r   <= TMAU_W_RESET;
			phys_r  <= TMAU_W_RESET;
			saved_r <= TMAU_SS_RESET;
			mstat_r <= TMAU_MS_RESET;
			tbase_r <= TMAU_W_RESET;
			exc_r   <= 1'b0;
			vec_r   <= TMAU_W_RESET;
			rdata_r <= TMAU_W_RESET;
			fault_r <= 1'b0;
			tlbw_r  <= '0;
		end else begin
			instr_miss_address_r <= instr_miss_address_nxt;
			data_miss_address_r <= data_miss_address_nxt;
			instr_compare_word_r  <= instr_compare_word_nxt;
			data_compare_word_r  <= data_compare_word_nxt;
			prim_r  <= prim_nxt;
			sec_r   <= sec_nxt;
			phys_r  <= phys_nxt;
			saved_r <= saved_nxt;
			mstat_r <= mstat_nxt;
			tbase_r <= tbase_nxt;
			exc_r   <= exc_nxt;
			vec_r   <= vec_nxt;
			rdata_r <= rdata_nxt;
			fault_r <= fault_nxt;
			tlbw_r  <= tlbw_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign EXC_TAKEN            = exc_r;
	assign EXC_VECTOR           = vec_r;
	assign SPR_RDATA            = rdata_r;
	assign PRIV_FAULT           = fault_r;
	assign MACHINE_STATE        = mstat_r;
	assign TEMP_REGISTER_SELECT = mstat_r[TMAU_MS_TEMP_REGISTER_SELECT];
	assign TLB_WRITE            = tlbw_r;

endmodule // tmau_top
`default_nettype wire

// ---- bench/tmau_properties.sv ----
// Purpose: port checks for tmau_top
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module tmau_checker
	import tmau_pkg::*;
(
	input wire logic          REF_CLK,
	input wire logic          RST_N,
	input wire logic          IFETCH_MISS,
	input wire logic          DATA_MISS,
	input wire logic          DATA_STORE_C0,
	input wire logic          DATA_IS_LOAD,
	input wire logic          OTHER_EXC,
	input wire logic          RFI,
	input wire tmau_spr_req_t SPR_REQ,
	input wire logic          ILOAD_REQ,
	input wire logic          DLOAD_REQ,
	input wire logic          EXC_TAKEN,
	input wire logic [31:0]   EXC_VECTOR,
	input wire logic          PRIV_FAULT,
	input wire logic [31:0]   MACHINE_STATE,
	input wire logic          TEMP_REGISTER_SELECT,
	input wire tmau_tlbw_t    TLB_WRITE
);
	logic m;
	logic pr;
	assign m = IFETCH_MISS | DATA_MISS | DATA_STORE_C0;
	assign pr = MACHINE_STATE[TMAU_MS_PR];
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	a_instr_miss_address_vector: assert property (IFETCH_MISS |=>
		EXC_TAKEN && EXC_VECTOR == TMAU_VEC_INSTR_MISS_ADDRESS)
		else $error("bad fetch miss vector");
	a_exc_pulse: assert property (!m |=> !EXC_TAKEN)
		else $error("stray exception");
	a_dload_vector: assert property (DATA_MISS && DATA_IS_LOAD && !IFETCH_MISS |=>
		EXC_VECTOR == TMAU_VEC_DLOAD)
		else $error("bad load miss vector");
	a_dstore_vector: assert property (
		!IFETCH_MISS && (DATA_MISS ? !DATA_IS_LOAD : DATA_STORE_C0) |=>
		EXC_VECTOR == TMAU_VEC_DSTORE)
		else $error("bad store miss vector");
	a_miss_temp_register_select: assert property (m |=> TEMP_REGISTER_SELECT && MACHINE_STATE[TMAU_MS_TEMP_REGISTER_SELECT])
		else $error("scratch select not set");
	a_xlate_off: assert property (m || OTHER_EXC |=>
		!MACHINE_STATE[TMAU_MS_IR] && !MACHINE_STATE[TMAU_MS_DR])
		else $error("translation left on");
	a_rfi_restore: assert property (RFI && !m |=> !TEMP_REGISTER_SELECT)
		else $error("scratch select kept after return");
	a_user_refused: assert property (pr && (SPR_REQ.req || ILOAD_REQ) |=>
		PRIV_FAULT && !TLB_WRITE.instr)
		else $error("user access not refused");
	a_iload_entry: assert property (ILOAD_REQ && !pr |=> TLB_WRITE.instr && !TLB_WRITE.data)
		else $error("entry load missing");
endmodule // tmau_checker
bind tmau_top tmau_checker i_chk (.*);
`default_nettype wire

// ---- bench/test_tlb_miss_assist_unit.sv ----
// Purpose: directed scenarios for tmau_top
// Assumes: inputs driven at falling edge
// Notes: expectations built from the bit layout
`timescale 1ns/1ps
`default_nettype none
module test_tlb_miss_assist_unit
	import tmau_pkg::*;
;
	logic          clk, rst_n, instr_miss_address, data_miss_address, st_c0, is_load, oth, rfi;
	logic          skey, ukey, iway, dway, ild, dld, exc, pf, temp_register_select;
	logic [3:0]    cr0;
	logic [23:0]   segment_virtual_id;
	logic [31:0]   ea, lea, vec, rdata, mstate, h;
	tmau_spr_req_t sq;
	tmau_tlbw_t    tw, ew;
	int            bad_count, tests_run, cycles;
	tmau_top i_dut (
		.REF_CLK(clk), .RST_N(rst_n), .IFETCH_MISS(instr_miss_address), .DATA_MISS(data_miss_address),
		.DATA_STORE_C0(st_c0), .DATA_IS_LOAD(is_load), .OTHER_EXC(oth), .RFI(rfi),
		.MISS_EA(ea), .SEGMENT_VIRTUAL_ID(segment_virtual_id), .SUPERVISOR_KEY(skey), .USER_KEY(ukey),
		.CONDITION_FIELD_ZERO(cr0), .INSTR_LRU_WAY(iway), .DATA_LRU_WAY(dway),
		.SPR_REQ(sq), .ILOAD_REQ(ild), .DLOAD_REQ(dld), .LOAD_EA(lea),
		.EXC_TAKEN(exc), .EXC_VECTOR(vec), .SPR_RDATA(rdata), .PRIV_FAULT(pf),
		.MACHINE_STATE(mstate), .TEMP_REGISTER_SELECT(temp_register_select), .TLB_WRITE(tw)
	);
	always #20 clk = ~clk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			print_verdict;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkw(input tmau_tlbw_t g, input tmau_tlbw_t e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Request held one full cycle, result ready at the next fall
	task automatic spr(input logic we, input tmau_sel_t s, input logic [31:0] d);
		@(negedge clk) sq = '{1'b1, we, s, d};
		@(negedge clk) sq.req = 1'b0;
	endtask
	task automatic rd(input tmau_sel_t s, input logic [31:0] e);
		spr(1'b0, s, 32'h0);
		chk(rdata, e);
	endtask
	task automatic hit(input logic [2:0] k, input logic l);
		@(negedge clk) {instr_miss_address, data_miss_address, st_c0, is_load} = {k, l};
		@(negedge clk) {instr_miss_address, data_miss_address, st_c0} = 3'b000;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask
	task automatic eload(input logic i);
		@(negedge clk) {ild, dld} = {i, !i};
		@(negedge clk) {ild, dld} = 2'b00;
	endtask
	task automatic t_instr_miss_address;
		spr(1'b1, TMAU_SEL_TBASE, 32'hFE00_0000);
		spr(1'b1, TMAU_SEL_MSTAT, 32'h0000_0030);
		{cr0, ea, segment_virtual_id, skey, iway} = {4'hA, 32'h1234_5678, 24'hABCDEF, 2'b11};
		hit(3'b100, 1'b0);
		chk({31'h0, exc}, 32'h1);
		chk(vec, TMAU_VEC_INSTR_MISS_ADDRESS);
		chk(mstate, 32'h0002_0000);
		chk({31'h0, temp_register_select}, 32'h1);
		rd(TMAU_SEL_INSTR_MISS_ADDRESS, ea);
		rd(TMAU_SEL_INSTR_COMPARE_WORD, {1'b1, segment_virtual_id, 1'b0, ea[27:22]});
		rd(TMAU_SEL_SAVED, 32'hA00E_0030);
		spr(1'b0, TMAU_SEL_PRIM, 32'h0);
		h = rdata;
		chk(h & 32'hFE00_003F, 32'hFE00_0000);
		spr(1'b0, TMAU_SEL_SEC, 32'h0);
		chk(h ^ rdata, 32'h01FF_FFC0);
	endtask
	task automatic t_load;
		spr(1'b1, TMAU_SEL_PHYS, 32'hCAFE_0012);
		spr(1'b1, TMAU_SEL_SAVED, 32'hA00C_0030);
		lea = 32'h0001_F000;
		eload(1'b1);
		ew = '{1'b1, 1'b0, 5'h1F, 1'b0, {1'b1, segment_virtual_id, 1'b0, ea[27:22]}, 32'hCAFE_0012};
		chkw(tw, ew);
	endtask
	task automatic t_data;
		{cr0, ea, dway} = {4'h5, 32'h8765_4320, 1'b1};
		hit(3'b010, 1'b1);
		chk(vec, TMAU_VEC_DLOAD);
		rd(TMAU_SEL_DATA_MISS_ADDRESS, ea);
		rd(TMAU_SEL_INSTR_MISS_ADDRESS, 32'h1234_5678);
		rd(TMAU_SEL_SAVED, 32'h500B_0000);
		eload(1'b0);
		ew = '{1'b0, 1'b1, 5'h1F, 1'b1, {1'b1, segment_virtual_id, 1'b0, ea[27:22]}, 32'hCAFE_0012};
		chkw(tw, ew);
		hit(3'b001, 1'b1);
		chk(vec, TMAU_VEC_DSTORE);
		// Fetch miss in between so the next store vector is really rewritten
		hit(3'b100, 1'b0);
		chk(vec, TMAU_VEC_INSTR_MISS_ADDRESS);
		hit(3'b010, 1'b0);
		chk(vec, TMAU_VEC_DSTORE);
		rd(TMAU_SEL_SAVED, 32'h500A_0000);
	endtask
	// Last scenario: user mode is kept through another exception and refuses support access
	task automatic t_user;
		spr(1'b1, TMAU_SEL_SAVED, 32'h0002_4030);
		pulse(rfi);
		chk(mstate, 32'h0000_4030);
		chk({31'h0, temp_register_select}, 32'h0);
		pulse(oth);
		chk(mstate, 32'h0000_4000);
		spr(1'b0, TMAU_SEL_INSTR_MISS_ADDRESS, 32'h0);
		chk({31'h0, pf}, 32'h1);
		eload(1'b1);
		chk({31'h0, pf}, 32'h1);
	endtask
	initial begin
		{clk, rst_n, instr_miss_address, data_miss_address, st_c0, is_load, oth, rfi} = '0;
		{skey, ukey, iway, dway, ild, dld, cr0, segment_virtual_id, ea, lea} = '0;
		sq = '0;
		bad_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(mstate, TMAU_MS_RESET);
		t_instr_miss_address;
		t_load;
		t_data;
		t_user;
		print_verdict;
	end
endmodule // test_tlb_miss_assist_unit
`default_nettype wire
